// [ums_defines.vh]
// Register offsets, field positions, reset values and codes for the modem status block
`ifndef UMS_DEFINES_VH
`define UMS_DEFINES_VH

// ----------------------------------------------------------------------------
// Register byte offsets on APB
// ----------------------------------------------------------------------------
`define UMS_OFF_MODEM_STATUS     12'h000
`define UMS_OFF_SCRATCH_PAD      12'h004
`define UMS_OFF_DIVISOR_LOW      12'h008
`define UMS_OFF_DIVISOR_HIGH     12'h00c
`define UMS_OFF_DIVISOR_FRACTION 12'h010
`define UMS_OFF_DEVICE_IDENTITY  12'h014
`define UMS_OFF_MODEM_CONTROL    12'h018
`define UMS_OFF_FEATURE_CONTROL  12'h01c
`define UMS_OFF_ENHANCED_FEATURE 12'h020
`define UMS_OFF_INTERRUPT_ENABLE 12'h024
`define UMS_OFF_LINE_STATUS      12'h028
`define UMS_OFF_FIFO_STATUS      12'h02c
`define UMS_OFF_ENHANCED_MODE    12'h030
`define UMS_OFF_DIVISOR_TOTAL    12'h034

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define UMS_MCR_DTR       0
`define UMS_MCR_RTS       1
`define UMS_MCR_OUT1      2
`define UMS_MCR_OUT2      3
`define UMS_MCR_LOOP      4
`define UMS_FCR_SWAP      6
`define UMS_EFR_ENH       4
`define UMS_EFR_ACTS      7
`define UMS_IER_MODEM     3
`define UMS_EMS_INV       3
`define UMS_EMS_LSR_IMM   6
`define UMS_EMS_SAMPLE16  7
`define UMS_LSR_FIFO_ERR  7

// ----------------------------------------------------------------------------
// Reset values and codes
// ----------------------------------------------------------------------------
`define UMS_RST_SCRATCH   8'hff
`define UMS_RST_EMS       8'h80
`define UMS_RST_ZERO      8'h00
`define UMS_DEVICE_ID     8'h5c
`define UMS_LVL_RX        2'h0
`define UMS_LVL_TX        2'h1
`define UMS_LVL_ALT       2'h3

`endif

// [ums_regs.v]
// Modem status, scratch swap, enhanced mode select and divisor register block
// Notes on behaviour
// - Line status bit 7 set while any receive FIFO byte carries an error tag.
// - That summary flag clears itself once no held byte carries an error.
// - Low four modem status bits flag input changes; interrupt when enable bit 3.
// - Ring change flag sets only on the rising edge of the ring input.
// - Modem status bit 4 is inverted clear-to-send pin, or RTS bit in loopback.
// - Bits 5-7 invert DSR, RI, CD pins; loopback shows DTR, bit 2, bit 3.
// - Auto CTS: high CTS halts transmit after current character; low resumes.
// - Scratch pad keeps contents in sleep and resets to ff.
// - With swap bit set, scratch writes go to enhanced mode select.
// - Mode select bits 1-0 choose receive, transmit or alternating level count.
// - Alternating mode returns receive count first, then toggles on every read.
// - Mode select bit 3 inverts the half-duplex direction output.
// - Four bits select RTS hysteresis from the sixteen-entry table.
// - Bit 6 clear: error interrupt when bad character reaches receive holding.
// - Bit 6 set: error interrupt as soon as bad character enters the FIFO.
// - Mode select bit 7 selects 16X sampling when set, 8X when clear.
// - With swap bit set, scratch reads return the chosen FIFO level count.
// - Divisor is high:low sixteen-bit value plus fraction over sixteen.
// - Fraction register writable only while enhanced feature bit 4 is set.
// - Modem control bit 4 enters loopback.
//
// Design decisions made here: the APB interface to the registers and the register addresses.
`include "ums_defines.vh"
`default_nettype none

module ums_regs (
  // APB
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Modem pins, active low
  input  wire        cts_n,
  input  wire        dsr_n,
  input  wire        ri_n,
  input  wire        cd_n,
  // Receive and transmit datapath status
  input  wire [7:0]  rx_level,
  input  wire [7:0]  tx_level,
  input  wire [7:0]  rx_err_count,
  input  wire        rx_push,
  input  wire        rx_push_err,
  input  wire        rhr_err,
  input  wire        tx_char_done,
  input  wire        tx_active,
  input  wire        sleep,
  // Controls to the rest of the channel
  output reg         tx_allow,
  output reg         modem_irq,
  output reg         line_err_irq,
  output reg         dir_rts_n,
  output reg  [5:0]  rts_hysteresis,
  output reg         sample_16x,
  output reg  [19:0] baud_divisor,
  output reg         loopback
);

  // --------------------------------------------------------------------------
  // Storage
  // --------------------------------------------------------------------------
  reg [7:0]  scratch_pad;
  reg [7:0]  enhanced_mode_select;
  reg [7:0]  divisor_low;
  reg [7:0]  divisor_high;
  reg [7:0]  divisor_fraction;
  reg [7:0]  modem_control;
  reg [7:0]  feature_control;
  reg [7:0]  enhanced_feature;
  reg [7:0]  interrupt_enable;
  reg [3:0]  delta;
  reg        alt_tx_next;
  reg        tx_halted;
  reg [3:0]  pin_s1;
  reg [3:0]  pin_s2;
  reg [3:0]  pin_prev;

  // --------------------------------------------------------------------------
  // Decode
  // --------------------------------------------------------------------------
  wire       access = psel & penable;
  wire       wr     = access & pwrite;
  wire       rd     = access & ~pwrite;
  wire [7:0] wb     = pwdata[7:0];
  wire       swap   = feature_control[`UMS_FCR_SWAP];

  function hit;
    input [11:0] off;
    begin
      hit = (paddr == off);
    end
  endfunction

  // --------------------------------------------------------------------------
  // Hysteresis table
  // --------------------------------------------------------------------------
  // Hysteresis table; index is extended bits 5:4 then feature bits 1:0
  function [5:0] hyst;
    input [3:0] sel;
    begin
      case (sel)
        4'h0: hyst = 6'd0;
        4'h1: hyst = 6'd4;
        4'h2: hyst = 6'd6;
        4'h3: hyst = 6'd8;
        4'h4: hyst = 6'd8;
        4'h5: hyst = 6'd16;
        4'h6: hyst = 6'd24;
        4'h7: hyst = 6'd32;
        4'h8: hyst = 6'd40;
        4'h9: hyst = 6'd44;
        4'ha: hyst = 6'd48;
        4'hb: hyst = 6'd52;
        4'hc: hyst = 6'd12;
        4'hd: hyst = 6'd20;
        4'he: hyst = 6'd28;
        default: hyst = 6'd36;
      endcase
    end
  endfunction

  // --------------------------------------------------------------------------
  // Modem status assembly
  // --------------------------------------------------------------------------
  // Pins synchronised; bit order cts, dsr, ri, cd, all made active high
  wire [3:0] pin_act = pin_s2;
  wire [3:0] msr_hi  = loopback ?
    {modem_control[`UMS_MCR_OUT2], modem_control[`UMS_MCR_OUT1],
     modem_control[`UMS_MCR_DTR], modem_control[`UMS_MCR_RTS]} :
    {pin_act[3], pin_act[2], pin_act[1], pin_act[0]};
  wire [7:0] modem_status = {msr_hi, delta};

  // --------------------------------------------------------------------------
  // Change detection
  // --------------------------------------------------------------------------
  wire [3:0] chg;
  assign chg[0] = msr_hi[0] ^ pin_prev[0];
  assign chg[1] = msr_hi[1] ^ pin_prev[1];
  assign chg[2] = ~msr_hi[2] & pin_prev[2];
  assign chg[3] = msr_hi[3] ^ pin_prev[3];

  // --------------------------------------------------------------------------
  // Level counter select
  // --------------------------------------------------------------------------
  // Only reachable through the swapped scratch location
  wire [1:0] lvl_mode = enhanced_mode_select[1:0];
  wire       lvl_rd   = rd & hit(`UMS_OFF_SCRATCH_PAD) & swap;
  reg  [7:0] level_sel;
  always @* begin
    if (!lvl_mode[0])
      level_sel = rx_level;
    else if (!lvl_mode[1])
      level_sel = tx_level;
    else
      level_sel = alt_tx_next ? tx_level : rx_level;
  end

  // --------------------------------------------------------------------------
  // Line status
  // --------------------------------------------------------------------------
  // Follows the error count, so the flag clears by itself with the last bad byte
  wire fifo_err = (rx_err_count != 8'h00);
  wire [7:0] line_status = {fifo_err, 7'h00};

  // --------------------------------------------------------------------------
  // Read multiplexer
  // --------------------------------------------------------------------------
  // Unmapped offsets clear known, which the slave turns into an error
  reg [7:0] rmux;
  reg       known;
  always @* begin
    rmux  = 8'h00;
    known = 1'b1;
    case (paddr)
      `UMS_OFF_MODEM_STATUS:     rmux = modem_status;
      `UMS_OFF_SCRATCH_PAD:      rmux = swap ? level_sel : scratch_pad;
      `UMS_OFF_DIVISOR_LOW:      rmux = divisor_low;
      `UMS_OFF_DIVISOR_HIGH:     rmux = divisor_high;
      `UMS_OFF_DIVISOR_FRACTION: rmux = divisor_fraction;
      `UMS_OFF_DEVICE_IDENTITY:  rmux = `UMS_DEVICE_ID;
      `UMS_OFF_MODEM_CONTROL:    rmux = modem_control;
      `UMS_OFF_FEATURE_CONTROL:  rmux = feature_control;
      `UMS_OFF_ENHANCED_FEATURE: rmux = enhanced_feature;
      `UMS_OFF_INTERRUPT_ENABLE: rmux = interrupt_enable;
      `UMS_OFF_LINE_STATUS:      rmux = line_status;
      `UMS_OFF_FIFO_STATUS:      rmux = rx_err_count;
      `UMS_OFF_ENHANCED_MODE:    rmux = enhanced_mode_select;
      `UMS_OFF_DIVISOR_TOTAL:    rmux = 8'h00;
      default:                   known = 1'b0;
    endcase
  end

  // --------------------------------------------------------------------------
  // APB slave: zero wait states, error on unmapped address
  // --------------------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~known;
      // Writes return zero so a refused write never shows stale data
      if (psel & ~penable & pwrite)
        prdata <= 32'h00000000;
      else if (psel & ~penable)
        prdata <= (paddr == `UMS_OFF_DIVISOR_TOTAL) ?
                  {12'h000, divisor_high, divisor_low, divisor_fraction[3:0]} :
                  {24'h000000, rmux};
    end
  end

  // --------------------------------------------------------------------------
  // Write commit
  // --------------------------------------------------------------------------
  // Writes take effect in the access cycle when pready is high
  wire wr_ok = wr & pready;
  wire rd_ok = rd & pready;

  // --------------------------------------------------------------------------
  // Write strobes
  // --------------------------------------------------------------------------
  wire wr_scratch  = wr_ok & hit(`UMS_OFF_SCRATCH_PAD) & ~swap;
  wire wr_ems      = wr_ok & hit(`UMS_OFF_SCRATCH_PAD) & swap;
  wire wr_div_lo   = wr_ok & hit(`UMS_OFF_DIVISOR_LOW);
  wire wr_div_hi   = wr_ok & hit(`UMS_OFF_DIVISOR_HIGH);
  wire wr_div_frac = wr_ok & hit(`UMS_OFF_DIVISOR_FRACTION) & enhanced_feature[`UMS_EFR_ENH];
  wire wr_mcr      = wr_ok & hit(`UMS_OFF_MODEM_CONTROL);
  wire wr_fcr      = wr_ok & hit(`UMS_OFF_FEATURE_CONTROL);
  wire wr_efr      = wr_ok & hit(`UMS_OFF_ENHANCED_FEATURE);
  wire wr_ier      = wr_ok & hit(`UMS_OFF_INTERRUPT_ENABLE);
  wire rd_msr      = rd_ok & hit(`UMS_OFF_MODEM_STATUS);
  wire lvl_step    = lvl_rd & pready & (lvl_mode == `UMS_LVL_ALT);

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scratch_pad          <= `UMS_RST_SCRATCH;
      enhanced_mode_select <= `UMS_RST_EMS;
      divisor_low          <= `UMS_RST_ZERO;
      divisor_high         <= `UMS_RST_ZERO;
      divisor_fraction     <= `UMS_RST_ZERO;
      modem_control        <= `UMS_RST_ZERO;
      feature_control      <= `UMS_RST_ZERO;
      enhanced_feature     <= `UMS_RST_ZERO;
      interrupt_enable     <= `UMS_RST_ZERO;
    end else begin
      // Sleep does not touch the scratch contents
      if (wr_scratch)
        scratch_pad <= wb;
      if (wr_ems)
        enhanced_mode_select <= wb;
      if (wr_div_lo)
        divisor_low <= wb;
      if (wr_div_hi)
        divisor_high <= wb;
      if (wr_div_frac)
        divisor_fraction <= wb;
      if (wr_mcr)
        modem_control <= wb;
      if (wr_fcr)
        feature_control <= wb;
      if (wr_efr)
        enhanced_feature <= wb;
      if (wr_ier)
        interrupt_enable <= wb;
    end
  end

  // --------------------------------------------------------------------------
  // Alternating level counter
  // --------------------------------------------------------------------------
  // Programming the mode restarts alternation at the receive count
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      alt_tx_next <= 1'b0;
    else if (wr_ems)
      alt_tx_next <= 1'b0;
    else if (lvl_step)
      alt_tx_next <= ~alt_tx_next;
  end

  // --------------------------------------------------------------------------
  // Modem input synchroniser
  // --------------------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1 <= 4'h0;
      pin_s2 <= 4'h0;
    end else begin
      pin_s1 <= {~cd_n, ~ri_n, ~dsr_n, ~cts_n};
      pin_s2 <= pin_s1;
    end
  end

  // --------------------------------------------------------------------------
  // Change flags
  // --------------------------------------------------------------------------
  // Only flags the read returned are cleared; later changes survive the clear
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_prev <= 4'h0;
      delta    <= 4'h0;
    end else begin
      pin_prev <= msr_hi;
      if (rd_msr)
        delta <= (delta & ~prdata[3:0]) | chg;
      else
        delta <= delta | chg;
    end
  end

  // --------------------------------------------------------------------------
  // Automatic clear-to-send gating
  // --------------------------------------------------------------------------
  // Halt only at a character boundary so no frame is cut short
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      tx_halted <= 1'b0;
    else if (~enhanced_feature[`UMS_EFR_ACTS] | msr_hi[0])
      tx_halted <= 1'b0;
    else if (tx_char_done | ~tx_active)
      tx_halted <= 1'b1;
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  wire next_dir = tx_active ^ enhanced_mode_select[`UMS_EMS_INV];

  // --------------------------------------------------------------------------
  // Error interrupt select
  // --------------------------------------------------------------------------
  wire err_ev   = enhanced_mode_select[`UMS_EMS_LSR_IMM] ?
                  rx_push & rx_push_err : rhr_err;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_allow       <= 1'b1;
      modem_irq      <= 1'b0;
      line_err_irq   <= 1'b0;
      dir_rts_n      <= 1'b1;
      rts_hysteresis <= 6'd0;
      sample_16x     <= 1'b1;
      baud_divisor   <= 20'h00000;
      loopback       <= 1'b0;
    end else begin
      tx_allow       <= ~tx_halted;
      modem_irq      <= (|delta) & interrupt_enable[`UMS_IER_MODEM];
      line_err_irq   <= err_ev;
      dir_rts_n      <= ~next_dir;
      rts_hysteresis <= hyst({enhanced_mode_select[5:4], feature_control[1:0]});
      sample_16x     <= enhanced_mode_select[`UMS_EMS_SAMPLE16];
      baud_divisor   <= {divisor_high, divisor_low, divisor_fraction[3:0]};
      loopback       <= modem_control[`UMS_MCR_LOOP];
    end
  end

endmodule // ums_regs
`default_nettype wire

// [ums_regs_chk.sv]
// Assertion checker for the modem status and enhanced register block
`default_nettype none
module ums_regs_chk (
  // APB
  input wire logic        pclk, presetn, psel, penable, pwrite, pready, pslverr,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  // Modem and datapath side
  input wire logic        cts_n, rx_push, rx_push_err, rhr_err, tx_char_done, tx_active,
  input wire logic [7:0]  rx_err_count,
  input wire logic        tx_allow, modem_irq, line_err_irq, dir_rts_n, sample_16x, loopback,
  input wire logic [19:0] baud_divisor
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic wr;
  logic rd_set;
  assign wr = psel && penable && pwrite && pready;
  assign rd_set = psel && !penable && !pwrite;
  a_pready_pulse: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("pready is not a one-cycle answer");
  a_unmapped_err: assert property (psel && !penable && paddr > 12'h034 |=> pslverr && prdata == 0)
    else $error("unmapped access not refused");
  a_fifo_err_flag: assert property (rd_set && paddr == 12'h028 |=>
    prdata[7] == ($past(rx_err_count) != 8'h00)) else $error("error summary flag wrong");
  a_line_irq_cause: assert property (line_err_irq |->
    $past(rhr_err || (rx_push && rx_push_err))) else $error("line irq without error");
  a_baud_write: assert property ($changed(baud_divisor) |->
    $past(wr && paddr inside {12'h008, 12'h00c, 12'h010}, 2)) else $error("divisor moved");
  a_dir_track: assert property ($changed(dir_rts_n) |->
    $past(tx_active, 2) != $past(tx_active) || $past(wr) || $past(wr, 2))
    else $error("direction output moved without cause");
  a_sample_hold: assert property ($changed(sample_16x) |-> $past(wr) || $past(wr, 2))
    else $error("sampling select moved without write");
  a_loop_hold: assert property ($changed(loopback) |-> $past(wr && paddr == 12'h018, 2))
    else $error("loopback moved without write");
  a_tx_halt_char: assert property ($fell(tx_allow) |-> $past(tx_char_done || !tx_active, 2))
    else $error("transmitter halted mid-character");
  a_cts_status: assert property ($stable(cts_n)[*4] ##0 (rd_set && paddr == 12'h000 &&
    !loopback) |=> prdata[4] == !$past(cts_n)) else $error("clear-to-send status wrong");
  c_swap_write: cover property (wr && paddr == 12'h004);
  c_modem_irq: cover property ($rose(modem_irq));
  c_line_irq: cover property ($rose(line_err_irq));
endmodule // ums_regs_chk
bind ums_regs ums_regs_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pready(pready), .pslverr(pslverr), .paddr(paddr),
  .prdata(prdata), .cts_n(cts_n), .rx_push(rx_push), .rx_push_err(rx_push_err),
  .rhr_err(rhr_err), .tx_char_done(tx_char_done), .tx_active(tx_active),
  .rx_err_count(rx_err_count), .tx_allow(tx_allow), .modem_irq(modem_irq),
  .line_err_irq(line_err_irq), .dir_rts_n(dir_rts_n), .sample_16x(sample_16x),
  .loopback(loopback), .baud_divisor(baud_divisor));
`default_nettype wire

// [ums_modem_model.sv]
// Far-side model: modem input pins and transmit character framing
`default_nettype none
module ums_modem_model (
  // Clock
  input  wire logic pclk,
  // Modem pins, active low
  output var  logic cts_n, dsr_n, ri_n, cd_n,
  // Transmitter state
  output var  logic tx_active, tx_char_done
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    {cd_n, ri_n, dsr_n, cts_n} = 4'hf;
    tx_active = 1'b0;
    tx_char_done = 1'b0;
  end
  task automatic pins(input logic [3:0] v);
    @(posedge pclk);
    {cd_n, ri_n, dsr_n, cts_n} <= v;
  endtask
  // Busy for n cycles; done marks the end of the character
  task automatic send(input int n);
    @(posedge pclk);
    tx_active <= 1'b1;
    repeat (n - 1) @(posedge pclk);
    tx_char_done <= 1'b1;
    @(posedge pclk);
    tx_active <= 1'b0;
    tx_char_done <= 1'b0;
  endtask
endmodule // ums_modem_model
`default_nettype wire

// [ums_regs_tb.sv]
// Self-checking testbench for the modem status and enhanced register block
`include "ums_defines.vh"
`default_nettype none
module ums_regs_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        cts_n, dsr_n, ri_n, cd_n, rx_push, rx_push_err, rhr_err, tx_char_done;
  logic        tx_active, sleep, tx_allow, modem_irq, line_err_irq, dir_rts_n, sample_16x;
  logic        loopback;
  logic [7:0]  rx_level, tx_level, rx_err_count, rd;
  logic [5:0]  rts_hysteresis;
  logic [19:0] baud_divisor;
  logic [5:0]  hyst [16] = '{0, 4, 6, 8, 8, 16, 24, 32, 40, 44, 48, 52, 12, 20, 28, 36};
  int          fail_count = 0;
  int          n_checks = 0;
  ums_regs dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cts_n(cts_n), .dsr_n(dsr_n), .ri_n(ri_n), .cd_n(cd_n),
    .rx_level(rx_level), .tx_level(tx_level), .rx_err_count(rx_err_count),
    .rx_push(rx_push), .rx_push_err(rx_push_err), .rhr_err(rhr_err),
    .tx_char_done(tx_char_done), .tx_active(tx_active), .sleep(sleep), .tx_allow(tx_allow),
    .modem_irq(modem_irq), .line_err_irq(line_err_irq), .dir_rts_n(dir_rts_n),
    .rts_hysteresis(rts_hysteresis), .sample_16x(sample_16x),
    .baud_divisor(baud_divisor), .loopback(loopback));
  ums_modem_model m (.pclk(pclk), .cts_n(cts_n), .dsr_n(dsr_n), .ri_n(ri_n), .cd_n(cd_n),
    .tx_active(tx_active), .tx_char_done(tx_char_done));
  always #12.5 pclk = ~pclk;
  task automatic stop_test;
    $display("Checks %0d, mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [19:0] g, input logic [19:0] e);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("Error at %0t: got %h, expected %h", $time, g, e);
    end
  endtask
  task automatic chkf(input logic g, input logic e);
    chk({19'h0, g}, {19'h0, e});
  endtask
  // Release after the sampled access edge, then one idle edge before the next setup
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      fail_count++;
      stop_test();
    end
    rd = prdata[7:0];
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    chk({12'h0, rd}, {12'h0, e});
  endtask
  task automatic pulse(input int k, input logic e);
    @(posedge pclk);
    if (k == 0) {rx_push, rx_push_err} <= 2'b11;
    else rhr_err <= 1'b1;
    @(posedge pclk);
    {rx_push, rx_push_err, rhr_err} <= 3'b000;
    @(posedge pclk);
    chkf(line_err_irq, e);
  endtask
  task automatic t_reset;
    chkf(sample_16x, 1'b1);
    rdc(12'h004, 8'hff);
    rdc(12'h030, 8'h80);
    apb(1'b1, 12'h008, 8'h00);
    apb(1'b1, 12'h00c, 8'h00);
    rdc(12'h014, `UMS_DEVICE_ID);
    apb(1'b0, 12'h03c, 8'h00);
    chk({11'h0, er, rd}, 20'h00100);
    $display("test reset done");
  endtask
  task automatic t_modem;
    apb(1'b1, 12'h024, 8'h08);
    apb(1'b0, 12'h000, 8'h00);
    m.pins(4'h0);
    repeat (5) @(posedge pclk);
    chkf(modem_irq, 1'b1);
    rdc(12'h000, 8'hfb);
    rdc(12'h000, 8'hf0);
    chkf(modem_irq, 1'b0);
    m.pins(4'h4);
    repeat (5) @(posedge pclk);
    rdc(12'h000, 8'hb4);
    $display("test modem done");
  endtask
  task automatic t_loop;
    apb(1'b1, 12'h018, 8'h15);
    repeat (4) @(posedge pclk);
    chkf(loopback, 1'b1);
    apb(1'b0, 12'h000, 8'h00);
    chk({12'h0, rd & 8'hf0}, 20'h00060);
    apb(1'b1, 12'h018, 8'h1a);
    repeat (4) @(posedge pclk);
    apb(1'b0, 12'h000, 8'h00);
    chk({12'h0, rd & 8'hf0}, 20'h00090);
    apb(1'b1, 12'h018, 8'h00);
    repeat (4) @(posedge pclk);
    apb(1'b0, 12'h000, 8'h00);
    $display("test loopback done");
  endtask
  task automatic t_swap;
    sleep <= 1'b1;
    rx_level <= 8'h03;
    tx_level <= 8'h07;
    apb(1'b1, 12'h004, 8'h5a);
    rdc(12'h004, 8'h5a);
    apb(1'b1, 12'h01c, 8'h40);
    apb(1'b1, 12'h004, 8'h83);
    rdc(12'h004, 8'h03);
    rdc(12'h004, 8'h07);
    rdc(12'h004, 8'h03);
    apb(1'b1, 12'h004, 8'h81);
    rdc(12'h004, 8'h07);
    apb(1'b1, 12'h004, 8'h02);
    rdc(12'h004, 8'h03);
    chkf(sample_16x, 1'b0);
    apb(1'b1, 12'h004, 8'h88);
    repeat (2) @(posedge pclk);
    chkf(dir_rts_n, 1'b0);
    for (int i = 0; i < 16; i++) begin
      apb(1'b1, 12'h01c, {6'h10, i[1:0]});
      apb(1'b1, 12'h004, {2'b10, i[3:2], 4'h0});
      @(posedge pclk);
      chk({14'h0, rts_hysteresis}, {14'h0, hyst[i]});
    end
    apb(1'b1, 12'h01c, 8'h00);
    rdc(12'h004, 8'h5a);
    sleep <= 1'b0;
    $display("test swap done");
  endtask
  task automatic t_div;
    apb(1'b1, 12'h020, 8'h00);
    apb(1'b1, 12'h010, 8'h05);
    apb(1'b1, 12'h008, 8'h34);
    apb(1'b1, 12'h00c, 8'h12);
    @(posedge pclk);
    chk(baud_divisor, 20'h12340);
    apb(1'b1, 12'h020, 8'h10);
    apb(1'b1, 12'h010, 8'h05);
    @(posedge pclk);
    chk(baud_divisor, 20'h12345);
    $display("test divisor done");
  endtask
  task automatic t_err;
    rx_err_count <= 8'h02;
    rdc(12'h028, 8'h80);
    rx_err_count <= 8'h00;
    rdc(12'h028, 8'h00);
    apb(1'b1, 12'h01c, 8'h40);
    apb(1'b1, 12'h004, 8'h80);
    pulse(0, 1'b0);
    pulse(1, 1'b1);
    apb(1'b1, 12'h004, 8'hc0);
    pulse(0, 1'b1);
    $display("test errors done");
  endtask
  task automatic t_cts;
    apb(1'b1, 12'h020, 8'h80);
    m.pins(4'h5);
    m.send(8);
    repeat (2) @(posedge pclk);
    chkf(tx_allow, 1'b0);
    m.pins(4'h4);
    repeat (5) @(posedge pclk);
    chkf(tx_allow, 1'b1);
    $display("test auto cts done");
  endtask
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {rx_push, rx_push_err, rhr_err, sleep} = 4'h0;
    {rx_level, tx_level, rx_err_count} = '0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (6) @(posedge pclk);
    t_reset();
    t_modem();
    t_loop();
    t_swap();
    t_div();
    t_err();
    t_cts();
    stop_test();
  end
  // Whole run needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge pclk);
    fail_count++;
    stop_test();
  end
endmodule // ums_regs_tb
`default_nettype wire
